// *** hw/status_led_pkg.sv ***
// Purpose: shared constants and types for the status LED sequencer
// Assumes: 200 MHz system clock
// Notes:   fault codes follow the bit order of fault_vec_type
package status_led_pkg;

	localparam int CLK_HZ          = 200_000_000;
	localparam int FLASH_ON_MS     = 250;
	localparam int FLASH_OFF_MS    = 250;
	localparam int GROUP_PAUSE_MS  = 1500;
	localparam int SLOW_HALF_MS    = 500;
	localparam int BLANK_MS        = 50;
	localparam int MOTOR_OFF_MS    = 2000;
	localparam int ACT_HOLD_MS     = 200;
	localparam int FLASH_ON_CYC    = CLK_HZ / 1000 * FLASH_ON_MS;
	localparam int FLASH_OFF_CYC   = CLK_HZ / 1000 * FLASH_OFF_MS;
	localparam int GROUP_PAUSE_CYC = CLK_HZ / 1000 * GROUP_PAUSE_MS;
	localparam int SLOW_HALF_CYC   = CLK_HZ / 1000 * SLOW_HALF_MS;
	localparam int BLANK_CYC       = CLK_HZ / 1000 * BLANK_MS;
	localparam int MOTOR_OFF_CYC   = CLK_HZ / 1000 * MOTOR_OFF_MS;
	localparam int ACT_HOLD_CYC    = CLK_HZ / 1000 * ACT_HOLD_MS;

	localparam int NUM_FAULTS      = 11;
	localparam int CNT_W           = 32;
	localparam int CODE_W          = 4;
	localparam logic [3:0] FW_VERSION = 4'h3; // Arbitrary value

	typedef enum logic [2:0] {
		ST_VER_ON   = 3'h0,
		ST_VER_OFF  = 3'h1,
		ST_NORMAL   = 3'h3,
		ST_FLT_ON   = 3'h2,
		ST_FLT_OFF  = 3'h6,
		ST_FLT_GAP  = 3'h7
	} led_state_type;

	typedef struct packed {
		logic pan_limit_sw;
		logic pan_soft_limit;
		logic tilt_limit_sw;
		logic tilt_soft_limit;
		logic pan_oc;
		logic tilt_oc;
		logic focus_oc;
		logic panel_oc;
		logic heater_oc;
		logic bad_limit_sw;
		logic datum_fail;
		logic product_bad;
		logic supply_bad;
	} fault_in_type;

	typedef struct packed {
		logic pan_en;
		logic tilt_en;
		logic focus_en;
		logic panel_en;
		logic heater_en;
	} out_en_type;

	typedef logic [NUM_FAULTS-1:0] fault_vec_type;

endpackage : status_led_pkg

// *** hw/status_led.sv ***
// Purpose: two-colour status LED sequencer and fault latch
// Assumes: fault and data inputs may be asynchronous to clk_in
// Notes:   bit n of the active vector is fault code n+1
//
// Contract
// - After reset flash green firmware-version times, then normal display.
// - Bus mode, no fault, no data: steady green.
// - Bus mode: each valid data strobe blanks green briefly.
// - Bus mode, continuous data: slow green flash.
// - DMX mode with data present: slow green flash.
// - DMX mode without data: steady green.
// - After the version flashes, any fault suppresses green; flash red fault-code times.
// - Several faults: groups in turn, pause between groups.
// - Code 1 pan limit switch or soft limit; code 2 tilt.
// - Motor overcurrent codes 3-5 disables motor for a period; latched.
// - Panel supply overcurrent switches output off until power cycle.
// - Heater overcurrent switches heater off until power cycle.
// - Code 8 when an unused limit switch input goes active.
// - Code 9 when datum procedure fails.
// - Code 10 when product type unset or corrupt.
// - Code 11 when supply voltage outside window.
`timescale 1ns/10ps
`default_nettype none
module status_led
	import status_led_pkg::*;
#(
	parameter int FLASH_ON    = FLASH_ON_CYC,
	parameter int FLASH_OFF   = FLASH_OFF_CYC,
	parameter int GROUP_PAUSE = GROUP_PAUSE_CYC,
	parameter int SLOW_HALF   = SLOW_HALF_CYC,
	parameter int BLANK       = BLANK_CYC,
	parameter int MOTOR_OFF   = MOTOR_OFF_CYC,
	parameter int ACT_HOLD    = ACT_HOLD_CYC
) (
	input  wire logic         clk_in,
	input  wire logic         resetn_in,
	input  wire fault_in_type faults_in,
	input  wire logic         data_valid_in,
	input  wire logic         dmx_mode_in,
	output logic              led_green_out,
	output logic              led_red_out,
	output out_en_type        out_en_out,
	output fault_vec_type     faults_out
);

	// Elaboration checks: a zero period would cut phases to one cycle or disable blank and hold
	if (FLASH_ON < 1) begin : g_bad_on
		$error("FLASH_ON must be at least 1");
	end
	if (FLASH_OFF < 1) begin : g_bad_off
		$error("FLASH_OFF must be at least 1");
	end
	if (GROUP_PAUSE < 1) begin : g_bad_pause
		$error("GROUP_PAUSE must be at least 1");
	end
	if (SLOW_HALF < 1) begin : g_bad_slow
		$error("SLOW_HALF must be at least 1");
	end
	if (BLANK < 1) begin : g_bad_blank
		$error("BLANK must be at least 1");
	end
	if (MOTOR_OFF < 1) begin : g_bad_motor
		$error("MOTOR_OFF must be at least 1");
	end
	if (ACT_HOLD < 1) begin : g_bad_hold
		$error("ACT_HOLD must be at least 1");
	end
	// Zero would wrap the flash counter to fifteen, giving sixteen flashes
	if (FW_VERSION == '0) begin : g_bad_version
		$error("FW_VERSION must be at least 1");
	end
	if (NUM_FAULTS >= (1 << CODE_W)) begin : g_bad_codes
		$error("fault codes do not fit the code counter");
	end

	typedef struct packed {
		fault_in_type        sync1;
		fault_in_type        sync2;
		logic [2:0]          dv_sync;
		logic                dmx1;
		logic                dmx2;
		led_state_type       state;
		logic [CNT_W-1:0]    timer;
		logic [CODE_W-1:0]   flashes;
		logic [CODE_W-1:0]   code;
		logic [CNT_W-1:0]    blank_cnt;
		logic [CNT_W-1:0]    act_cnt;
		logic [CNT_W-1:0]    burst_cnt;
		logic [CNT_W-1:0]    slow_cnt;
		logic                slow_phase;
		logic [2:0]          motor_latch;
		logic [2:0][CNT_W-1:0] motor_cnt;
		logic                panel_trip;
		logic                heater_trip;
		logic                green;
		logic                red;
		out_en_type          en;
		fault_vec_type       fv;
	} state_type;

	state_type s;
	state_type next_s;

	// Next active fault code strictly after cur, wrapping; 0 when none
	function automatic logic [CODE_W-1:0] next_code(
		input fault_vec_type     v,
		input logic [CODE_W-1:0] cur
	);
		logic [CODE_W-1:0] r;
		logic [CODE_W-1:0] c;
		r = '0;
		for (int i = NUM_FAULTS; i >= 1; i--) begin
			c = CODE_W'(i);
			if (v[i-1] && c > cur)
				r = c;
		end
		if (r == '0) begin
			for (int i = NUM_FAULTS; i >= 1; i--) begin
				if (v[i-1])
					r = CODE_W'(i);
			end
		end
		return r;
	endfunction : next_code

	function automatic logic [CNT_W-1:0] dec(input logic [CNT_W-1:0] x);
		return (x == '0) ? '0 : x - CNT_W'(1);
	endfunction : dec

	fault_vec_type fvec;
	logic          dv_pulse;
	logic          any_fault;

	always_comb begin
		next_s = s;
		fvec = '0;
		next_s.sync1 = faults_in;
		next_s.sync2 = s.sync1;
		next_s.dv_sync = {s.dv_sync[1:0], data_valid_in};
		next_s.dmx1 = dmx_mode_in;
		next_s.dmx2 = s.dmx1;
		dv_pulse = s.dv_sync[1] & ~s.dv_sync[2];

		// Motor trips: disable for a period, indication held while latched
		for (int m = 0; m < 3; m++) begin
			next_s.motor_cnt[m] = dec(s.motor_cnt[m]);
			if (s.motor_cnt[m] == CNT_W'(1) || s.motor_cnt[m] == '0)
				next_s.motor_latch[m] = s.motor_latch[m] &
				                        (s.motor_cnt[m] != '0);
		end
		if (s.sync2.pan_oc) begin
			next_s.motor_latch[0] = 1'b1;
			next_s.motor_cnt[0] = CNT_W'(MOTOR_OFF);
		end
		if (s.sync2.tilt_oc) begin
			next_s.motor_latch[1] = 1'b1;
			next_s.motor_cnt[1] = CNT_W'(MOTOR_OFF);
		end
		if (s.sync2.focus_oc) begin
			next_s.motor_latch[2] = 1'b1;
			next_s.motor_cnt[2] = CNT_W'(MOTOR_OFF);
		end
		// Only reset clears these; power cycle is the only restore
		if (s.sync2.panel_oc)
			next_s.panel_trip = 1'b1;
		if (s.sync2.heater_oc)
			next_s.heater_trip = 1'b1;
		next_s.en.pan_en    = ~next_s.motor_latch[0];
		next_s.en.tilt_en   = ~next_s.motor_latch[1];
		next_s.en.focus_en  = ~next_s.motor_latch[2];
		next_s.en.panel_en  = ~next_s.panel_trip;
		next_s.en.heater_en = ~next_s.heater_trip;

		fvec[0]  = s.sync2.pan_limit_sw | s.sync2.pan_soft_limit;
		fvec[1]  = s.sync2.tilt_limit_sw | s.sync2.tilt_soft_limit;
		fvec[2]  = s.motor_latch[0];
		fvec[3]  = s.motor_latch[1];
		fvec[4]  = s.motor_latch[2];
		fvec[5]  = s.panel_trip;
		fvec[6]  = s.heater_trip;
		fvec[7]  = s.sync2.bad_limit_sw;
		fvec[8]  = s.sync2.datum_fail;
		fvec[9]  = s.sync2.product_bad;
		fvec[10] = s.sync2.supply_bad;
		next_s.fv = fvec;
		any_fault = |fvec;

		// Activity tracking; a strobe gap below ACT_HOLD counts as continuous
		next_s.blank_cnt = dec(s.blank_cnt);
		next_s.act_cnt = dec(s.act_cnt);
		if (dv_pulse) begin
			next_s.blank_cnt = CNT_W'(BLANK);
			next_s.act_cnt = CNT_W'(ACT_HOLD);
			next_s.burst_cnt = (s.act_cnt != '0) ?
			                   s.burst_cnt + CNT_W'(1) : '0;
		end else if (s.act_cnt == '0) begin
			next_s.burst_cnt = '0;
		end
		next_s.slow_cnt = dec(s.slow_cnt);
		if (s.slow_cnt == '0) begin
			next_s.slow_cnt = CNT_W'(SLOW_HALF);
			next_s.slow_phase = ~s.slow_phase;
		end

		next_s.timer = dec(s.timer);
		next_s.green = 1'b0;
		next_s.red = 1'b0;
		case (s.state)
		ST_VER_ON: begin
			next_s.green = 1'b1;
			if (s.timer == '0) begin
				next_s.state = ST_VER_OFF;
				next_s.timer = CNT_W'(FLASH_OFF);
				next_s.flashes = s.flashes - CODE_W'(1);
				next_s.green = 1'b0;
			end
		end
		ST_VER_OFF: begin
			if (s.timer == '0) begin
				if (s.flashes == '0) begin
					next_s.state = ST_NORMAL;
				end else begin
					next_s.state = ST_VER_ON;
					next_s.timer = CNT_W'(FLASH_ON);
					next_s.green = 1'b1;
				end
			end
		end
		ST_NORMAL: begin
			if (any_fault) begin
				next_s.code = next_code(fvec, '0);
				next_s.flashes = next_code(fvec, '0);
				next_s.state = ST_FLT_ON;
				next_s.timer = CNT_W'(FLASH_ON);
				next_s.red = 1'b1;
			end else if (s.dmx2) begin
				// Slow flash while DMX frames arrive, else steady
				next_s.green = (s.act_cnt != '0) ?
				               s.slow_phase : 1'b1;
			end else if (s.burst_cnt > CNT_W'(2)) begin
				next_s.green = s.slow_phase;
			end else begin
				next_s.green = (s.blank_cnt == '0);
			end
		end
		ST_FLT_ON: begin
			next_s.red = 1'b1;
			if (s.timer == '0) begin
				next_s.red = 1'b0;
				next_s.flashes = s.flashes - CODE_W'(1);
				next_s.state = ST_FLT_OFF;
				next_s.timer = CNT_W'(FLASH_OFF);
			end
		end
		ST_FLT_OFF: begin
			if (s.timer == '0) begin
				if (s.flashes == '0) begin
					next_s.state = ST_FLT_GAP;
					next_s.timer = CNT_W'(GROUP_PAUSE);
				end else begin
					next_s.state = ST_FLT_ON;
					next_s.timer = CNT_W'(FLASH_ON);
					next_s.red = 1'b1;
				end
			end
		end
		ST_FLT_GAP: begin
			if (s.timer == '0) begin
				if (!any_fault) begin
					next_s.state = ST_NORMAL;
				end else begin
					next_s.code = next_code(fvec, s.code);
					next_s.flashes = next_code(fvec, s.code);
					next_s.state = ST_FLT_ON;
					next_s.timer = CNT_W'(FLASH_ON);
					next_s.red = 1'b1;
				end
			end
		end
		default: begin
			next_s.state = ST_NORMAL;
		end
		endcase
	end

	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			s <= '0;
			s.state <= ST_VER_ON;
			s.timer <= CNT_W'(FLASH_ON);
			s.flashes <= FW_VERSION;
			s.en <= '1;
		end else begin
			s <= next_s;
		end
	end

	assign led_green_out = s.green;
	assign led_red_out   = s.red;
	assign out_en_out    = s.en;
	assign faults_out    = s.fv;

endmodule : status_led
`default_nettype wire

// *** bench/status_led_sva.sv ***
// Purpose: port checks for status_led
// Assumes: fault inputs held five cycles or more
// Notes:   bound to every status_led instance
`timescale 1ns/10ps
`default_nettype none
module status_led_sva
	import status_led_pkg::*;
(
	input wire logic          clk_in,
	input wire logic          resetn_in,
	input wire fault_in_type  faults_in,
	input wire logic          data_valid_in,
	input wire logic          dmx_mode_in,
	input wire logic          led_green_out,
	input wire logic          led_red_out,
	input wire out_en_type    out_en_out,
	input wire fault_vec_type faults_out
);
	default clocking @(posedge clk_in); endclocking
	default disable iff (!resetn_in);
	start_green_a: assert property ($rose(resetn_in) |=> led_green_out)
		else $error("no green after reset");
	colour_excl_a: assert property (led_red_out |-> !led_green_out)
		else $error("red and green together");
	pan_code_a: assert property (
		faults_in.pan_soft_limit [*5] |-> faults_out[0])
		else $error("pan limit not reported");
	pan_oc_off_a: assert property (
		faults_in.pan_oc [*5] |-> !out_en_out.pan_en && faults_out[2])
		else $error("pan motor not disabled");
	panel_hold_a: assert property (
		!out_en_out.panel_en |=> !out_en_out.panel_en)
		else $error("panel supply restored");
	heater_hold_a: assert property (
		!out_en_out.heater_en |=> !out_en_out.heater_en)
		else $error("heater restored");
	limit_err_a: assert property (
		faults_in.bad_limit_sw [*5] |-> faults_out[7])
		else $error("limit error not reported");
	supply_err_a: assert property (
		faults_in.supply_bad [*5] |-> faults_out[10])
		else $error("supply error not reported");
endmodule : status_led_sva
bind status_led status_led_sva chk_i (.clk_in(clk_in),
	.resetn_in(resetn_in), .faults_in(faults_in),
	.data_valid_in(data_valid_in), .dmx_mode_in(dmx_mode_in),
	.led_green_out(led_green_out), .led_red_out(led_red_out),
	.out_en_out(out_en_out), .faults_out(faults_out));
`default_nettype wire

// *** bench/status_led_tb.sv ***
// Purpose: self-checking bench for status_led
// Assumes: short timing parameters
// Notes:   expected flash counts come from a queue model of active codes
`timescale 1ns/10ps
`default_nettype none
module status_led_tb
	import status_led_pkg::*;
;
	logic          clk_in        = 1'b0;
	logic          resetn_in     = 1'b0;
	fault_in_type  faults_in     = '0;
	logic          data_valid_in = 1'b0;
	logic          dmx_mode_in   = 1'b0;
	logic          led_green_out;
	logic          led_red_out;
	out_en_type    out_en_out;
	fault_vec_type faults_out;
	int            err_count = 0;
	int            checks    = 0;
	int            n;
	int            m;
	int            code_of[13] = '{1, 1, 2, 2, 3, 4, 5, 6, 7, 8, 9, 10, 11};
	int            exp_q[$];
	int            v;
	localparam int T_ON    = 4;
	localparam int T_OFF   = 4;
	localparam int T_PAUSE = 12;
	localparam int T_SLOW  = 6;
	localparam int T_BLANK = 5;
	localparam int T_MOTOR = 20;
	localparam int T_HOLD  = 10;
	always #2.5 clk_in = ~clk_in;
	status_led #(.FLASH_ON(T_ON), .FLASH_OFF(T_OFF),
		.GROUP_PAUSE(T_PAUSE), .SLOW_HALF(T_SLOW), .BLANK(T_BLANK),
		.MOTOR_OFF(T_MOTOR), .ACT_HOLD(T_HOLD)) dut (
		.clk_in(clk_in), .resetn_in(resetn_in), .faults_in(faults_in),
		.data_valid_in(data_valid_in), .dmx_mode_in(dmx_mode_in),
		.led_green_out(led_green_out), .led_red_out(led_red_out),
		.out_en_out(out_en_out), .faults_out(faults_out));
	task automatic results;
		if (err_count == 0 && checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : results
	task automatic chk(input logic ok, input string s);
		checks++;
		if (ok !== 1'b1) begin
			err_count++;
			$display("CHECK FAILED %0t %s", $time, s);
		end
	endtask : chk
	// Model: active codes in ascending order, each code once
	function automatic void model(input fault_in_type f);
		exp_q.delete();
		for (int b = 0; b < 13; b++) begin
			if (f[12 - b] && (exp_q.size() == 0 || exp_q[$] != code_of[b]))
				exp_q.push_back(code_of[b]);
		end
	endfunction : model
	task automatic cyc(input int k);
		repeat (k) @(posedge clk_in);
		#1;
	endtask : cyc
	task automatic watch(input int k, output int r, output int l);
		logic p;
		p = led_green_out;
		r = 0;
		l = 0;
		repeat (k) begin
			cyc(1);
			r += (led_green_out && !p);
			l += !led_green_out;
			p = led_green_out;
		end
	endtask : watch
	// Gap longer than one off phase marks a group boundary
	task automatic group(output int cnt, input int lo);
		int q;
		logic p;
		cnt = 0;
		q = 0;
		while (lo < 9 && q < 400) begin
			cyc(1);
			q++;
			lo = led_red_out ? 0 : lo + 1;
		end
		lo = 0;
		p = 1'b0;
		while (lo < 9 && q < 400) begin
			cyc(1);
			q++;
			cnt += (led_red_out && !p);
			p = led_red_out;
			// Rest of the pause may be nine lows long; wait for a flash
			lo = (led_red_out || cnt == 0) ? 0 : lo + 1;
		end
		if (q >= 400) begin
			chk(1'b0, "hang");
			results();
		end
	endtask : group
	// Gaps stay under the activity hold so data counts as continuous
	task automatic strobes(output int r);
		int r1;
		int l1;
		r = 0;
		repeat (30) begin
			data_valid_in = 1'b1;
			cyc(1);
			data_valid_in = 1'b0;
			watch($urandom_range(6, 3), r1, l1);
			r += r1;
		end
	endtask : strobes
	initial begin
		void'($urandom(32'h5478cb81));
		cyc(10);
		resetn_in = 1'b1;
		watch(27, n, m);
		chk(n == FW_VERSION, "version");
		cyc(10);
		watch(40, n, m);
		chk(m == 0 && led_red_out === 1'b0, "steady");
		data_valid_in = 1'b1;
		cyc(1);
		data_valid_in = 1'b0;
		watch(30, n, m);
		chk(m > 0 && m < 12 && led_green_out === 1'b1, "blank");
		strobes(n);
		chk(n >= 4, "slow");
		cyc(30);
		dmx_mode_in = 1'b1;
		watch(30, n, m);
		chk(m == 0, "dmx idle");
		strobes(n);
		chk(n >= 4, "dmx data");
		dmx_mode_in = 1'b0;
		cyc(30);
		for (int i = 0; i < 13; i++) begin
			faults_in = fault_in_type'(13'h1000 >> i);
			model(faults_in);
			cyc(6);
			m = 1 << (exp_q[0] - 1);
			chk(faults_out === fault_vec_type'(m), "code");
			group(n, 0);
			chk(n == exp_q[0] && !led_green_out, "count");
			m = (i > 3 && i < 9) ? 5'h1F ^ (5'h1 << (8 - i)) : 5'h1F;
			chk(out_en_out === out_en_type'(m), "enable");
			faults_in = '0;
			cyc(8);
			n = exp_q[0] - 1;
			chk(faults_out[n] === (i > 3 && i < 9), "latch");
			cyc(40);
			chk(faults_out[n] === (i == 7 || i == 8), "hold");
			// Panel and heater stay off until power returns
			resetn_in = 1'b0;
			cyc(3);
			resetn_in = 1'b1;
			cyc(40);
		end
		// One random travel limit and one random non-latching error
		n = $urandom_range(3, 0);
		m = $urandom_range(12, 9);
		faults_in = fault_in_type'((13'h1000 >> n) | (13'h1000 >> m));
		model(faults_in);
		cyc(6);
		m = (1 << (exp_q[0] - 1)) | (1 << (exp_q[1] - 1));
		chk(faults_out === fault_vec_type'(m), "pair");
		group(n, 0);
		group(m, 9);
		v = exp_q[0] * exp_q[1];
		chk(n + m == exp_q[0] + exp_q[1] && n * m == v, "multi");
		results();
	end
endmodule : status_led_tb
`default_nettype wire
